// ### verilog/udc_pkg.sv
// Purpose: shared constants and state type for the usb device control core
// Assumes: 8-bit register port, 50 MHz core clock
// Notes:   offsets are byte addresses on the plain register port
package udc_pkg;

  // clock rate and line timing
  localparam int CLK_MHZ       = 50;
  localparam int BUS_RESET_US  = 100;
  localparam int SUSPEND_MS    = 3;
  localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;
  localparam int SUSPEND_CYC   = SUSPEND_MS * 1000 * CLK_MHZ;
  localparam int CNT_W         = 18;
  localparam int EP_NUM        = 5;
  localparam int DPRAM_BYTES   = 176;

  // register offsets
  localparam logic [7:0] ADDR_REGULATOR = 8'h63;
  localparam logic [7:0] ADDR_MACRO_CTL = 8'hD8;
  localparam logic [7:0] ADDR_DEV_CTL   = 8'hE0;
  localparam logic [7:0] ADDR_DEV_FLAGS = 8'hE1;
  localparam logic [7:0] ADDR_DEV_IEN   = 8'hE2;
  localparam logic [7:0] ADDR_DEV_ADDR  = 8'hE3;
  localparam logic [7:0] ADDR_EP_SEL    = 8'hE9;
  localparam logic [7:0] ADDR_EP_RST    = 8'hEA;
  localparam logic [7:0] ADDR_EP_CTL    = 8'hEB;
  localparam logic [7:0] ADDR_EP_CFG_A  = 8'hEC;
  localparam logic [7:0] ADDR_EP_CFG_B  = 8'hED;
  localparam logic [7:0] ADDR_EP_STAT   = 8'hEE;
  localparam logic [7:0] ADDR_PAD       = 8'hEF;

  // field positions
  localparam int BIT_MACRO_ON  = 7;
  localparam int BIT_FREEZE    = 5;
  localparam int BIT_DETACH    = 0;
  localparam int BIT_HW_RST    = 3;
  localparam int BIT_SUSPEND   = 0;
  localparam int BIT_WAKE      = 4;
  localparam int BIT_ADDR_OK   = 7;
  localparam int BIT_EP_ACTIVE = 0;
  localparam int BIT_TGL_CLR   = 3;
  localparam int BIT_EP_DIR    = 0;
  localparam int BIT_CFG_OK    = 7;
  localparam int BIT_RESERVE   = 1;
  localparam int BIT_REG_OFF   = 0;

  // codes and reset values
  localparam logic [1:0] DRIVE_DIRECT = 2'h2;
  localparam logic [1:0] BANK_SINGLE  = 2'h0;
  localparam logic [1:0] BANK_DOUBLE  = 2'h1;
  localparam logic [2:0] SIZE_MAX     = 3'h3;
  localparam logic       FREEZE_RST   = 1'h1;
  localparam logic       DETACH_RST   = 1'h1;
  localparam int         FIRST_PINGPONG_EP = 3;

  typedef struct packed {
    logic [2:0]      dp_sync;
    logic [2:0]      dm_sync;
    logic            dp_level;
    logic            dm_level;
    logic            usb_macro_on;
    logic            usb_clock_freeze;
    logic            hw_reset_opt;
    logic            detach;
    logic            regulator_off;
    logic [1:0]      pad_drive_select;
    logic [1:0]      pad_drive_values;
    logic [6:0]      device_address_field;
    logic            address_valid;
    logic            suspend_flag;
    logic            wake_flag;
    logic            susp_irq_on;
    logic            wake_irq_on;
    logic [2:0]      endpoint_select_number;
    logic [4:0]      endpoint_active;
    logic [4:0]      endpoint_direction;
    logic [4:0][1:0] endpoint_transfer_type;
    logic [4:0][2:0] endpoint_size;
    logic [4:0][1:0] bank_count;
    logic [4:0]      memory_reserve;
    logic [4:0]      config_valid_flag;
    logic [4:0]      ep_ack_ok;
    logic [4:0]      ep_rst_pulse;
    logic [4:0]      tgl_clr_pulse;
    logic [CNT_W-1:0] se0_cnt;
    logic            se0_done;
    logic [CNT_W-1:0] idle_cnt;
    logic            idle_done;
    logic            cpu_rst;
    logic            addr_match;
    logic [7:0]      rdata;
    logic            pad_oe;
    logic            dp_drive;
    logic            dm_drive;
    logic            pullup_on;
    logic            clk_run;
    logic            susp_irq;
    logic            wake_irq;
  } udc_state_t;

  localparam udc_state_t STATE_RST = '{usb_clock_freeze: FREEZE_RST,
                                       detach: DETACH_RST,
                                       default: '0};

endpackage

// ### verilog/udc_core.sv
// Purpose: control core of a full-speed usb function: pads, reset, endpoints,
//          address, suspend and wake flags, pull-up detach
// Assumes: dp_in/dm_in are raw pad levels; token inputs come from clk_in logic
// Notes:   all state is one struct registered in one process
// Notes on behaviour
// - pad select 00 disables direct drive, 10 drives pads from the values
// - in direct drive, upper value bit goes to D+, lower to D-
// - pad status bits show sampled D+ (bit1) and D- (bit0), bits 3:2 zero
// - regulator register bit0 resets to zero, one switches regulator off
// - endpoint 0 plus four endpoints up to 64 bytes, 3 and 4 double bank
// - reset state: clock frozen, defaults, detach set, banks clear, no pull-up
// - detach resets to one and disconnects the pull-up while set
// - clearing macro enable resets the controller at any time, but keeps clock freeze, regulator and pad sampling
// - endpoint reset bit resets that endpoint, keeps toggle and configuration
// - SE0 for 100 us disables endpoints, keeps ep0 config, clears ep0 toggle
// - with hardware reset option a bus reset also resets the cpu core
// - endpoint number field routes all endpoint accesses except the reset register, which takes one bit per endpoint
// - an endpoint stays in reset until its active bit is set
// - no acknowledge to an endpoint whose configuration is not valid
// - configuration valid stays clear when size exceeds the packet memory
// - clearing active resets the endpoint and its data toggle, keeps config
// - with address valid answer stored address only, else address zero
// - address resets to zero; valid cleared by reset, bus reset, macro off
// - 3 ms of idle J sets the suspend flag and its interrupt if enabled
// - the lines leaving idle J for any other pattern set the wake flag
// - wake flag set clears suspend flag and suspend set clears wake
// - pad drive writes only work while enabled, reads always work
// - clock freeze stops the controller but keeps flags, wake stays alive
`timescale 1ns/1ps

module udc_core #(
  parameter int BUS_RESET_CYCLES = udc_pkg::BUS_RESET_CYC, // SE0 time for bus reset
  parameter int SUSPEND_CYCLES   = udc_pkg::SUSPEND_CYC    // idle time for suspend
) (
  input  wire logic       clk_in,           // core clock
  input  wire logic       nrst_in,          // async reset, active low
  input  wire logic [7:0] addr_in,          // register address
  input  wire logic [7:0] wdata_in,         // register write data
  input  wire logic       wr_in,            // write strobe
  input  wire logic       rd_in,            // read strobe
  output logic      [7:0] rdata_out,        // read data, cycle after strobe
  input  wire logic       dp_in,            // D+ pad level
  input  wire logic       dm_in,            // D- pad level
  output logic            dp_drive_out,     // D+ direct drive value
  output logic            dm_drive_out,     // D- direct drive value
  output logic            pad_drive_oe_out, // high while pads driven directly
  output logic            pullup_on_out,    // D+ pull-up connected
  output logic            regulator_off_out,// internal regulator disabled
  output logic            usb_clk_run_out,  // controller clock running
  output logic            cpu_reset_out,    // one-cycle cpu reset request
  output logic            suspend_irq_out,  // suspend interrupt level
  output logic            wake_irq_out,     // wake interrupt level
  output logic      [2:0] ep_select_out,    // endpoint routed to the datapath
  output logic      [4:0] ep_active_out,    // endpoint out of reset when high
  output logic      [4:0] ep_ack_ok_out,    // endpoint may acknowledge packets
  output logic      [4:0] ep_reset_out,     // one-cycle endpoint reset
  output logic      [4:0] toggle_clear_out, // one-cycle data toggle clear
  input  wire logic [6:0] token_addr_in,    // address of a received token
  input  wire logic       token_valid_in,   // token address valid, one cycle
  output logic            addr_match_out    // token was for this device
);

  udc_pkg::udc_state_t st;
  udc_pkg::udc_state_t next_st;
  logic [4:0]          cfg_fit;
  localparam int       CNT_BITS = udc_pkg::CNT_W; // width of both line timers

  // memory check per endpoint; overlap between endpoints is not checked here
  genvar e;
  generate
    for (e = 0; e < udc_pkg::EP_NUM; e++)
    begin : g_fit
      logic [9:0] bytes;
      logic [9:0] total;
      logic       bank_ok;
      assign bytes = 10'h008 << st.endpoint_size[e];
      assign total = (st.bank_count[e] == udc_pkg::BANK_DOUBLE) ? (bytes << 1) : bytes;
      assign bank_ok = (st.bank_count[e] == udc_pkg::BANK_SINGLE) ||
                       ((st.bank_count[e] == udc_pkg::BANK_DOUBLE) &&
                        (e >= udc_pkg::FIRST_PINGPONG_EP));
      assign cfg_fit[e] = st.memory_reserve[e] && bank_ok &&
                          (st.endpoint_size[e] <= udc_pkg::SIZE_MAX) &&
                          (total <= 10'(udc_pkg::DPRAM_BYTES));
    end
  endgenerate

  // next-state logic for the whole core
  always_comb
  begin
    udc_pkg::udc_state_t n;
    udc_pkg::udc_state_t r;
    logic line_j;
    logic line_se0;
    logic was_j;
    logic ep_ok;
    logic run;
    logic susp_evt;
    logic wake_evt;
    logic br_evt;
    logic [2:0] idx;
    n = st;
    r = udc_pkg::STATE_RST;
    idx = st.endpoint_select_number;
    ep_ok = (idx < 3'(udc_pkg::EP_NUM));
    run = st.usb_macro_on && !st.usb_clock_freeze;
    n.ep_rst_pulse = '0;
    n.tgl_clr_pulse = '0;
    n.cpu_rst = 1'h0;
    n.addr_match = 1'h0;
    n.rdata = 8'h00;
    susp_evt = 1'h0;
    br_evt = 1'h0;

    // three-stage pad sampling; a level counts when stages two and three agree
    n.dp_sync = {st.dp_sync[1:0], dp_in};
    n.dm_sync = {st.dm_sync[1:0], dm_in};
    if (st.dp_sync[1] == st.dp_sync[2])
      n.dp_level = st.dp_sync[2];
    if (st.dm_sync[1] == st.dm_sync[2])
      n.dm_level = st.dm_sync[2];
    line_j = n.dp_level && !n.dm_level;
    line_se0 = !n.dp_level && !n.dm_level;
    was_j = st.dp_level && !st.dm_level;
    wake_evt = was_j && !line_j;

    // register writes
    if (wr_in)
    begin
      case (addr_in)
        udc_pkg::ADDR_MACRO_CTL:
        begin
          n.usb_macro_on = wdata_in[udc_pkg::BIT_MACRO_ON];
          n.usb_clock_freeze = wdata_in[udc_pkg::BIT_FREEZE];
        end
        udc_pkg::ADDR_REGULATOR:
          n.regulator_off = wdata_in[udc_pkg::BIT_REG_OFF];
        udc_pkg::ADDR_PAD:
          if (st.usb_macro_on)
          begin
            n.pad_drive_select = wdata_in[7:6];
            n.pad_drive_values = wdata_in[5:4];
          end
        udc_pkg::ADDR_DEV_CTL:
        begin
          n.detach = wdata_in[udc_pkg::BIT_DETACH];
          n.hw_reset_opt = wdata_in[udc_pkg::BIT_HW_RST];
        end
        udc_pkg::ADDR_DEV_FLAGS:
        begin
          // writing zero clears a flag; a same-cycle hardware set still wins below
          if (!wdata_in[udc_pkg::BIT_SUSPEND])
            n.suspend_flag = 1'h0;
          if (!wdata_in[udc_pkg::BIT_WAKE])
            n.wake_flag = 1'h0;
        end
        udc_pkg::ADDR_DEV_IEN:
        begin
          n.susp_irq_on = wdata_in[udc_pkg::BIT_SUSPEND];
          n.wake_irq_on = wdata_in[udc_pkg::BIT_WAKE];
        end
        udc_pkg::ADDR_DEV_ADDR:
        begin
          n.device_address_field = wdata_in[6:0];
          n.address_valid = wdata_in[udc_pkg::BIT_ADDR_OK];
        end
        udc_pkg::ADDR_EP_SEL:
          n.endpoint_select_number = wdata_in[2:0];
        udc_pkg::ADDR_EP_RST:
          n.ep_rst_pulse = wdata_in[4:0];
        udc_pkg::ADDR_EP_CTL:
          if (ep_ok)
          begin
            n.endpoint_active[idx] = wdata_in[udc_pkg::BIT_EP_ACTIVE];
            if (st.endpoint_active[idx] && !wdata_in[udc_pkg::BIT_EP_ACTIVE])
            begin
              n.ep_rst_pulse[idx] = 1'h1;
              n.tgl_clr_pulse[idx] = 1'h1;
            end
            if (wdata_in[udc_pkg::BIT_TGL_CLR])
              n.tgl_clr_pulse[idx] = 1'h1;
          end
        udc_pkg::ADDR_EP_CFG_A:
          if (ep_ok)
          begin
            n.endpoint_transfer_type[idx] = wdata_in[7:6];
            n.endpoint_direction[idx] = wdata_in[udc_pkg::BIT_EP_DIR];
          end
        udc_pkg::ADDR_EP_CFG_B:
          if (ep_ok)
          begin
            n.endpoint_size[idx] = wdata_in[6:4];
            n.bank_count[idx] = wdata_in[3:2];
            n.memory_reserve[idx] = wdata_in[udc_pkg::BIT_RESERVE];
          end
        default:
        begin
        end
      endcase
    end

    // line timers only run on an unfrozen clock; counts hold meanwhile, wake still sets
    if (run)
    begin
      if (line_j)
      begin
        if (!st.idle_done)
          n.idle_cnt = st.idle_cnt + 1'h1;
        if (st.idle_cnt == CNT_BITS'(SUSPEND_CYCLES - 1) && !st.idle_done)
        begin
          susp_evt = 1'h1;
          n.idle_done = 1'h1;
        end
      end
      else
      begin
        n.idle_cnt = '0;
        n.idle_done = 1'h0;
      end
      if (line_se0)
      begin
        if (!st.se0_done)
          n.se0_cnt = st.se0_cnt + 1'h1;
        if (st.se0_cnt == CNT_BITS'(BUS_RESET_CYCLES - 1) && !st.se0_done)
        begin
          br_evt = 1'h1;
          n.se0_done = 1'h1;
        end
      end
      else
      begin
        n.se0_cnt = '0;
        n.se0_done = 1'h0;
      end
    end

    // hardware sets come after software clears so the set wins
    if (susp_evt)
    begin
      n.suspend_flag = 1'h1;
      n.wake_flag = 1'h0;
    end
    if (wake_evt)
    begin
      n.wake_flag = 1'h1;
      n.suspend_flag = 1'h0;
    end

    // bus reset keeps ep0 configuration but drops every endpoint
    if (br_evt)
    begin
      n.endpoint_active = '0;
      n.ep_rst_pulse = '1;
      n.tgl_clr_pulse[0] = 1'h1;
      n.device_address_field = 7'h00;
      n.address_valid = 1'h0;
      n.cpu_rst = st.hw_reset_opt;
    end

    // register reads, data valid only in the following cycle
    if (rd_in)
    begin
      case (addr_in)
        udc_pkg::ADDR_MACRO_CTL:
          n.rdata = {st.usb_macro_on, 1'h0, st.usb_clock_freeze, 5'h00};
        udc_pkg::ADDR_REGULATOR:
          n.rdata = {7'h00, st.regulator_off};
        udc_pkg::ADDR_PAD:
          n.rdata = {st.pad_drive_select, st.pad_drive_values, 2'h0,
                     st.dp_level, st.dm_level};
        udc_pkg::ADDR_DEV_CTL:
          n.rdata = {4'h0, st.hw_reset_opt, 2'h0, st.detach};
        udc_pkg::ADDR_DEV_FLAGS:
          n.rdata = {3'h0, st.wake_flag, 3'h0, st.suspend_flag};
        udc_pkg::ADDR_DEV_IEN:
          n.rdata = {3'h0, st.wake_irq_on, 3'h0, st.susp_irq_on};
        udc_pkg::ADDR_DEV_ADDR:
          n.rdata = {st.address_valid, st.device_address_field};
        udc_pkg::ADDR_EP_SEL:
          n.rdata = {5'h00, st.endpoint_select_number};
        udc_pkg::ADDR_EP_CTL:
          n.rdata = ep_ok ? {7'h00, st.endpoint_active[idx]} : 8'h00;
        udc_pkg::ADDR_EP_CFG_A:
          n.rdata = ep_ok ? {st.endpoint_transfer_type[idx], 5'h00,
                             st.endpoint_direction[idx]} : 8'h00;
        udc_pkg::ADDR_EP_CFG_B:
          n.rdata = ep_ok ? {1'h0, st.endpoint_size[idx], st.bank_count[idx],
                             st.memory_reserve[idx], 1'h0} : 8'h00;
        udc_pkg::ADDR_EP_STAT:
          n.rdata = ep_ok ? {st.config_valid_flag[idx], 7'h00} : 8'h00;
        default:
          n.rdata = 8'h00;
      endcase
    end

    // token address filter
    if (token_valid_in)
      n.addr_match = st.address_valid ? (token_addr_in == st.device_address_field)
                                      : (token_addr_in == 7'h00);
    n.config_valid_flag = cfg_fit;

    // macro off: everything but the macro control, regulator, pad sampling and read data resets
    if (!n.usb_macro_on)
    begin
      r.usb_clock_freeze = n.usb_clock_freeze;
      r.regulator_off = n.regulator_off;
      r.dp_sync = n.dp_sync;
      r.dm_sync = n.dm_sync;
      r.dp_level = n.dp_level;
      r.dm_level = n.dm_level;
      r.rdata = n.rdata;
      n = r;
    end

    // registered pin and status outputs
    n.pad_oe = n.usb_macro_on && (n.pad_drive_select == udc_pkg::DRIVE_DIRECT);
    n.dp_drive = n.pad_drive_values[1];
    n.dm_drive = n.pad_drive_values[0];
    n.pullup_on = n.usb_macro_on && !n.detach;
    n.clk_run = n.usb_macro_on && !n.usb_clock_freeze;
    n.susp_irq = n.suspend_flag && n.susp_irq_on;
    n.wake_irq = n.wake_flag && n.wake_irq_on;
    n.ep_ack_ok = n.endpoint_active & n.config_valid_flag & ~n.ep_rst_pulse;
    next_st = n;
  end

  // state register; reset state has frozen clock and detach set
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st <= udc_pkg::STATE_RST;
    else
      st <= next_st;
  end

  assign rdata_out         = st.rdata;
  assign dp_drive_out      = st.dp_drive;
  assign dm_drive_out      = st.dm_drive;
  assign pad_drive_oe_out  = st.pad_oe;
  assign pullup_on_out     = st.pullup_on;
  assign regulator_off_out = st.regulator_off;
  assign usb_clk_run_out   = st.clk_run;
  assign cpu_reset_out     = st.cpu_rst;
  assign suspend_irq_out   = st.susp_irq;
  assign wake_irq_out      = st.wake_irq;
  assign ep_select_out     = st.endpoint_select_number;
  assign ep_active_out     = st.endpoint_active;
  assign ep_ack_ok_out     = st.ep_ack_ok;
  assign ep_reset_out      = st.ep_rst_pulse;
  assign toggle_clear_out  = st.tgl_clr_pulse;
  assign addr_match_out    = st.addr_match;

  // checks on the driven behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // output enable is registered together with the stored select code
  a_drive_select_code: assert property (pad_drive_oe_out |->
    (st.pad_drive_select == udc_pkg::DRIVE_DIRECT) && st.usb_macro_on)
    else $error("direct drive without select code 10");
  a_drive_value_map: assert property ((st.pad_drive_values == 2'h1) && pad_drive_oe_out
    |-> !dp_drive_out && dm_drive_out)
    else $error("drive values mapped to wrong pad");
  a_pad_readback: assert property (rd_in && addr_in == udc_pkg::ADDR_PAD |=>
    rdata_out[3:0] == {2'h0, $past(st.dp_level), $past(st.dm_level)})
    else $error("pad level readback wrong");
  a_regulator_write: assert property (wr_in && addr_in == udc_pkg::ADDR_REGULATOR
    |=> regulator_off_out == $past(wdata_in[0]))
    else $error("regulator bit not stored");
  a_macro_off_clear: assert property (!st.usb_macro_on |-> !pullup_on_out &&
    !st.address_valid && ep_active_out == 5'h00)
    else $error("macro off left controller state");
  a_bus_reset_addr: assert property (cpu_reset_out |->
    st.device_address_field == 7'h00 && !st.address_valid && toggle_clear_out[0] &&
    ep_active_out == 5'h00)
    else $error("bus reset effects missing");
  a_ack_needs_cfg: assert property ((ep_ack_ok_out & ~st.config_valid_flag) == 5'h00)
    else $error("ack allowed on invalid configuration");
  a_flags_exclusive: assert property (!(st.suspend_flag && st.wake_flag))
    else $error("suspend and wake flags both set");
  // a disabled macro answers nothing, so only an enabled, unwritten cycle counts
  a_default_address: assert property (token_valid_in && !st.address_valid &&
    st.usb_macro_on && !wr_in |=>
    addr_match_out == ($past(token_addr_in) == 7'h00))
    else $error("default address match wrong");
  a_deactivate_reset: assert property (wr_in && addr_in == udc_pkg::ADDR_EP_CTL &&
    st.usb_macro_on && st.endpoint_select_number == 3'h1 && st.endpoint_active[1] &&
    !wdata_in[udc_pkg::BIT_EP_ACTIVE] |=> ep_reset_out[1] && toggle_clear_out[1])
    else $error("endpoint deactivation without reset");
  a_freeze_holds: assert property (st.usb_clock_freeze && st.usb_macro_on &&
    !(wr_in && addr_in == udc_pkg::ADDR_MACRO_CTL) |=> $stable(st.idle_cnt))
    else $error("line timer ran while frozen");

  c_suspend_seen: cover property ($rose(st.suspend_flag));
  c_wake_seen: cover property ($rose(st.wake_flag));
  c_bus_reset: cover property ($rose(toggle_clear_out[0]) && ep_active_out == 5'h00);
  c_direct_drive: cover property ($rose(pad_drive_oe_out));

endmodule // udc_core

// ### tb/udc_host_model.sv
// Purpose: host side line model driving the D+/D- levels
// Assumes: full-speed lines idle in J
// Notes:   state code 0 is J, 1 is K, 2 is SE0
`timescale 1ns/1ps
module udc_host_model (
  input  wire logic       clk_in,   // core clock
  input  wire logic [1:0] state_in, // line state asked by the bench
  output logic            dp_out,   // D+ level
  output logic            dm_out    // D- level
);
  // step the lines just after an edge so the sync flops see clean steps
  always_ff @(posedge clk_in)
  begin
    dp_out <= (state_in == 2'h0);
    dm_out <= (state_in == 2'h1);
  end
endmodule // udc_host_model

// ### tb/test_usb_device_control_core.sv
// Purpose: self-checking bench for the usb device control core
// Assumes: bus reset and suspend counts shortened to 20 and 40 cycles
// Notes:   pad wires take the device drive over the host model
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end end
module test_usb_device_control_core;
  localparam int BR = 20;
  localparam int SP = 40;
  localparam logic [1:0] CODES [3] = '{2'h1, 2'h3, 2'h0};
  logic       clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, tv = 0, saw_cpu = 0, saw_br = 0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata;
  logic [6:0] ta = 7'h00;
  logic [1:0] line = 2'h0;
  logic       h_dp, h_dm, dpd, dmd, oe, pu, roff, crun, crst, sirq, wirq, match;
  logic [4:0] act, ack, eprst, tgl;
  logic [2:0] esel;
  int         errors = 0, total_checks = 0;

  // the device wins the wires while it drives them directly
  udc_host_model udc_host_model_inst (.clk_in(clk_in), .state_in(line), .dp_out(h_dp),
    .dm_out(h_dm));
  udc_core #(.BUS_RESET_CYCLES(BR), .SUSPEND_CYCLES(SP)) udc_core_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .dp_in(oe ? dpd : h_dp),
    .dm_in(oe ? dmd : h_dm), .dp_drive_out(dpd), .dm_drive_out(dmd),
    .pad_drive_oe_out(oe), .pullup_on_out(pu), .regulator_off_out(roff),
    .usb_clk_run_out(crun), .cpu_reset_out(crst), .suspend_irq_out(sirq),
    .wake_irq_out(wirq), .ep_select_out(esel), .ep_active_out(act), .ep_ack_ok_out(ack),
    .ep_reset_out(eprst), .toggle_clear_out(tgl), .token_addr_in(ta), .token_valid_in(tv),
    .addr_match_out(match));

  // clock, and latches for the one-cycle bus reset pulses
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (crst === 1'b1) saw_cpu <= 1'b1;
  always @(posedge clk_in) if (tgl === 5'h01 && eprst === 5'h1F) saw_br <= 1'b1;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  task automatic tok(input logic [6:0] a, input logic e);
    @(posedge clk_in);
    ta <= a;
    tv <= 1'b1;
    @(posedge clk_in);
    tv <= 1'b0;
    #1;
    `CHK("match", e, match)
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog well past the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(8'h63, 8'h00, "regulator");
    rd(8'hD8, 8'h20, "macro ctl");
    rd(8'hE0, 8'h01, "dev ctl");
    `CHK("pullup", 1'b0, pu)
    wr(8'hEF, 8'hB0);
    rd(8'hEF, 8'h02, "pad off");
    $display("test reset done");
    wr(8'hD8, 8'h80);
    `CHK("clk run", 1'b1, crun)
    wr(8'hEF, 8'h90);
    `CHK("oe", 1'b1, oe)
    `CHK("dp drive", 1'b0, dpd)
    `CHK("dm drive", 1'b1, dmd)
    repeat (6) @(posedge clk_in);
    rd(8'hEF, 8'h91, "pad drive");
    foreach (CODES[i])
    begin
      wr(8'hEF, {CODES[i], 6'h30});
      `CHK("oe off", 1'b0, oe)
    end
    wr(8'h63, 8'hFF);
    `CHK("reg off", 1'b1, roff)
    rd(8'h63, 8'h01, "regulator");
    wr(8'hE0, 8'h08);
    `CHK("pullup", 1'b1, pu)
    $display("test pads done");
    tok(7'h00, 1'b1);
    wr(8'hE3, 8'h05);
    tok(7'h00, 1'b1);
    wr(8'hE3, 8'h85);
    tok(7'h05, 1'b1);
    tok(7'h00, 1'b0);
    $display("test address done");
    wr(8'hE9, 8'h01);
    `CHK("ep sel", 3'h1, esel)
    wr(8'hEB, 8'h01);
    `CHK("active", 5'h02, act)
    wr(8'hED, 8'h32);
    rd(8'hEE, 8'h80, "cfg ok");
    `CHK("ack ok", 1'b1, ack[1])
    wr(8'hEA, 8'h02);
    `CHK("ep rst", 5'h02, eprst)
    rd(8'hEB, 8'h01, "ep kept");
    wr(8'hE9, 8'h02);
    rd(8'hEB, 8'h00, "ep select");
    wr(8'hE9, 8'h01);
    wr(8'hED, 8'h42);
    rd(8'hEE, 8'h00, "cfg big");
    `CHK("ack off", 1'b0, ack[1])
    wr(8'hEB, 8'h00);
    `CHK("deact rst", 5'h02, eprst)
    `CHK("deact tgl", 5'h02, tgl)
    wr(8'hEB, 8'h09);
    `CHK("react", 5'h02, act)
    `CHK("tgl cmd", 5'h02, tgl)
    `CHK("no rst", 5'h00, eprst)
    $display("test endpoint done");
    wr(8'hE2, 8'h11);
    repeat (SP + 10) @(posedge clk_in);
    rd(8'hE1, 8'h01, "suspend");
    `CHK("susp irq", 1'b1, sirq)
    wr(8'hD8, 8'hA0);
    `CHK("clk frozen", 1'b0, crun)
    rd(8'hE1, 8'h01, "frozen flags");
    line <= 2'h1;
    repeat (10) @(posedge clk_in);
    line <= 2'h0;
    repeat (6) @(posedge clk_in);
    rd(8'hE1, 8'h10, "wake");
    `CHK("wake irq", 1'b1, wirq)
    wr(8'hD8, 8'h80);
    line <= 2'h2;
    repeat (BR + 10) @(posedge clk_in);
    line <= 2'h0;
    repeat (4) @(posedge clk_in);
    `CHK("bus rst act", 5'h00, act)
    rd(8'hE3, 8'h00, "address");
    `CHK("cpu reset", 1'b1, saw_cpu)
    `CHK("bus rst pulses", 1'b1, saw_br)
    $display("test line done");
    wr(8'hD8, 8'h00);
    `CHK("clk off", 1'b0, crun)
    `CHK("pullup off", 1'b0, pu)
    rd(8'hE0, 8'h01, "dev ctl");
    $display("test macro off done");
    summarize();
  end
endmodule // test_usb_device_control_core
